/* File: twm_consts.svh */
// Register offsets, field positions, reset values, status codes and timing counts
`ifndef TWM_CONSTS_SVH
`define TWM_CONSTS_SVH

// Register byte offsets
`define TWM_CTRL_OFS 8'h00
`define TWM_STAT_OFS 8'h04
`define TWM_DATA_OFS 8'h08

// Control register field positions
`define TWM_BIT_FLAG 7
`define TWM_BIT_ACK 6
`define TWM_BIT_START 5
`define TWM_BIT_STOP 4
`define TWM_BIT_WCOL 3
`define TWM_BIT_EN 2
`define TWM_BIT_IRQEN 0

// Reset values and status read mask
`define TWM_CTRL_RST 8'h00
`define TWM_DATA_RST 8'hFF
`define TWM_STAT_MASK 8'hF8

// Status codes, prescaler bits zero
`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_AW_ACK 8'h18
`define TWM_ST_AW_NACK 8'h20
`define TWM_ST_DT_ACK 8'h28
`define TWM_ST_DT_NACK 8'h30
`define TWM_ST_ARB_LOST 8'h38
`define TWM_ST_AR_ACK 8'h40
`define TWM_ST_AR_NACK 8'h48
`define TWM_ST_DR_ACK 8'h50
`define TWM_ST_DR_NACK 8'h58
`define TWM_ST_NONE 8'hF8

// Quarter of a serial bit time, and its length in system clocks
`define TWM_QUARTER_NS 2500
`define TWM_CLK_MHZ 125
`define TWM_QUARTER_CYC ((`TWM_QUARTER_NS * `TWM_CLK_MHZ) / 1000)

// Last bit index of a byte plus its acknowledge bit
`define TWM_ACK_BIT 4'h8

`endif

/* File: twm_pkg.sv */
// Types shared by the two-wire master receiver
package twm_pkg;

  // Control register layout
  typedef struct packed {
    logic event_flag;
    logic ack_enable;
    logic start_request;
    logic stop_request;
    logic write_collision_flag;
    logic interface_enable;
    logic reserved;
    logic irq_enable;
  } twm_ctrl_t;

  // Bus engine states
  typedef enum logic [2:0] {
    TWM_IDLE,
    TWM_START,
    TWM_RSTART,
    TWM_SHIFT,
    TWM_HOLD,
    TWM_STOP
  } twm_state_t;

endpackage : twm_pkg

/* File: twm_pin_tick.sv */
// Pin synchronisers and quarter-bit tick divider
module twm_pin_tick #(
  parameter int QUARTER_CYC = 312
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_sync_out,
  output logic sda_sync_out,
  output logic tick_out
);

  logic [1:0] scl_meta_reg; // Two-stage clock line sync
  logic [1:0] sda_meta_reg; // Two-stage data line sync
  logic [15:0] div_reg; // Divider count
  logic [15:0] div_next;
  logic tick_reg; // One-cycle quarter tick
  logic tick_next;

  // Divider next value
  always_comb begin
    if (div_reg == 16'(QUARTER_CYC - 1)) begin
      div_next = 16'h0000;
      tick_next = 1'b1;
    end else begin
      div_next = div_reg + 16'h0001;
      tick_next = 1'b0;
    end
  end

  // Registers of syncs and divider
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_meta_reg <= 2'h3;
      sda_meta_reg <= 2'h3;
      div_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      scl_meta_reg <= {scl_meta_reg[0], scl_in};
      sda_meta_reg <= {sda_meta_reg[0], sda_in};
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign scl_sync_out = scl_meta_reg[1];
  assign sda_sync_out = sda_meta_reg[1];
  assign tick_out = tick_reg;

endmodule : twm_pin_tick

/* File: twm_master_rx.sv */
// Two-wire master receiver: register port, bus engine and pin drive
`include "twm_consts.svh"
module twm_master_rx #(
  parameter int QUARTER_CYC = `TWM_QUARTER_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out
);

  logic [1:0] rst_sync_reg; // Reset release synchroniser
  logic rst_b; // Synchronised reset
  logic scl_s; // Synced clock line
  logic sda_s; // Synced data line
  logic tick; // Quarter-bit enable

  // Register group
  twm_pkg::twm_ctrl_t ctrl_reg;
  twm_pkg::twm_ctrl_t ctrl_next;
  twm_pkg::twm_ctrl_t wr_ctrl; // Write data seen as control fields
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Engine group
  twm_pkg::twm_state_t state_reg;
  twm_pkg::twm_state_t state_next;
  logic [1:0] phase_reg; // Quarter within a bit
  logic [1:0] phase_next;
  logic [3:0] bit_reg; // Bit index, 8 is acknowledge
  logic [3:0] bit_next;
  logic [7:0] shift_reg; // Serial shift register
  logic [7:0] shift_next;
  logic [7:0] code_reg; // Status code
  logic [7:0] code_next;
  logic rx_mode_reg; // Receiving data bytes
  logic rx_mode_next;
  logic addr_reg; // Current byte is an address
  logic addr_next;
  logic rep_reg; // START in progress is repeated
  logic rep_next;
  logic ack_reg; // Acknowledge seen low on bit 8
  logic ack_next;
  logic busy_reg; // Bus owned by someone
  logic busy_next;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_drv_reg; // Pull clock line low
  logic scl_drv_next;
  logic sda_drv_reg; // Pull data line low
  logic sda_drv_next;

  // Engine to register strobes
  logic set_flag; // Event completed
  logic load_rx; // Received byte to data register
  logic stop_done; // STOP sent
  logic xmit; // Engine sends the current byte

  // Data line drive for a bit: transmitter bits, or our acknowledge
  function automatic logic twm_sda_drive(input logic tx, input logic [3:0] idx,
                                         input logic b7, input logic ack_en);
    logic drv;
    drv = 1'b0;
    if (tx) begin
      drv = (idx < `TWM_ACK_BIT) ? ~b7 : 1'b0;
    end else begin
      drv = (idx == `TWM_ACK_BIT) ? ack_en : 1'b0;
    end
    return drv;
  endfunction : twm_sda_drive

  // Reset release through two flops
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_reg[1];

  // Pin sync and tick source
  twm_pin_tick #(
    .QUARTER_CYC(QUARTER_CYC)
  ) u_pin_tick (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_sync_out(scl_s),
    .sda_sync_out(sda_s),
    .tick_out(tick)
  );

  assign wr_ctrl = twm_pkg::twm_ctrl_t'(reg_wdata_in);

  // Register next values: writes, hardware events, reads
  always_comb begin
    ctrl_next = ctrl_reg;
    data_next = data_reg;
    rdata_next = 8'h00;
    if (stop_done) begin
      ctrl_next.stop_request = 1'b0;
    end
    if (reg_wr_in && reg_addr_in == `TWM_CTRL_OFS) begin
      ctrl_next.ack_enable = wr_ctrl.ack_enable;
      ctrl_next.start_request = wr_ctrl.start_request;
      ctrl_next.stop_request = wr_ctrl.stop_request;
      ctrl_next.interface_enable = wr_ctrl.interface_enable;
      ctrl_next.irq_enable = wr_ctrl.irq_enable;
      if (wr_ctrl.event_flag) begin
        ctrl_next.event_flag = 1'b0;
      end
    end else if (reg_wr_in && reg_addr_in == `TWM_DATA_OFS) begin
      if (ctrl_reg.event_flag) begin
        data_next = reg_wdata_in;
        ctrl_next.write_collision_flag = 1'b0;
      end else begin
        ctrl_next.write_collision_flag = 1'b1;
      end
    end
    if (load_rx) begin
      data_next = shift_reg;
    end
    // Hardware set wins over a clear
    if (set_flag) begin
      ctrl_next.event_flag = 1'b1;
    end
    if (reg_rd_in) begin
      if (reg_addr_in == `TWM_CTRL_OFS) begin
        rdata_next = ctrl_reg;
        rdata_next[1] = 1'b0;
      end else if (reg_addr_in == `TWM_STAT_OFS) begin
        rdata_next = code_reg & `TWM_STAT_MASK;
      end else if (reg_addr_in == `TWM_DATA_OFS) begin
        rdata_next = data_reg;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  // Register flops
  always_ff @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= twm_pkg::twm_ctrl_t'(`TWM_CTRL_RST);
      data_reg <= `TWM_DATA_RST;
      rdata_reg <= 8'h00;
    end else begin
      ctrl_reg <= ctrl_next;
      data_reg <= data_next;
      rdata_reg <= rdata_next;
    end
  end

  assign xmit = addr_reg | ~rx_mode_reg;

  // Bus engine next values
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    code_next = code_reg;
    rx_mode_next = rx_mode_reg;
    addr_next = addr_reg;
    rep_next = rep_reg;
    ack_next = ack_reg;
    scl_drv_next = scl_drv_reg;
    sda_drv_next = sda_drv_reg;
    set_flag = 1'b0;
    load_rx = 1'b0;
    stop_done = 1'b0;
    // Bus monitor: START sets busy, STOP clears it
    busy_next = busy_reg;
    if (scl_s && scl_prev_reg && sda_prev_reg && !sda_s) begin
      busy_next = 1'b1;
    end else if (scl_s && scl_prev_reg && !sda_prev_reg && sda_s) begin
      busy_next = 1'b0;
    end
    if (!ctrl_reg.interface_enable) begin
      state_next = twm_pkg::TWM_IDLE;
      scl_drv_next = 1'b0;
      sda_drv_next = 1'b0;
      code_next = `TWM_ST_NONE;
    end else begin
      case (state_reg)
        twm_pkg::TWM_IDLE: begin
          scl_drv_next = 1'b0;
          sda_drv_next = 1'b0;
          if (ctrl_reg.start_request && !ctrl_reg.event_flag && !busy_reg) begin
            state_next = twm_pkg::TWM_START;
            phase_next = 2'h0;
            rep_next = 1'b0;
          end
        end
        twm_pkg::TWM_RSTART: begin
          // Mark the coming START as repeated
          rep_next = 1'b1;
          // Release data, then clock, then fall into START
          if (tick && phase_reg == 2'h0) begin
            scl_drv_next = 1'b0;
            phase_next = 2'h1;
          end else if (tick && scl_s) begin
            sda_drv_next = 1'b1;
            state_next = twm_pkg::TWM_START;
            phase_next = 2'h1;
          end
        end
        twm_pkg::TWM_START: begin
          if (tick) begin
            phase_next = phase_reg + 2'h1;
            case (phase_reg)
              2'h0: begin
                // Another master may have taken the bus meanwhile
                if (busy_reg) begin
                  state_next = twm_pkg::TWM_IDLE;
                end else begin
                  sda_drv_next = 1'b1;
                end
              end
              2'h2: scl_drv_next = 1'b1;
              2'h3: begin
                code_next = rep_reg ? `TWM_ST_RSTART : `TWM_ST_START;
                set_flag = 1'b1;
                state_next = twm_pkg::TWM_HOLD;
              end
              default: phase_next = 2'h2;
            endcase
          end
        end
        twm_pkg::TWM_SHIFT: begin
          if (tick) begin
            case (phase_reg)
              2'h0: begin
                scl_drv_next = 1'b0;
                phase_next = 2'h1;
              end
              2'h1: begin
                // Slave may stretch the clock
                if (scl_s) begin
                  phase_next = 2'h2;
                end
              end
              2'h2: begin
                if (bit_reg < `TWM_ACK_BIT) begin
                  shift_next = {shift_reg[6:0], sda_s};
                end else begin
                  ack_next = ~sda_s;
                end
                if (!sda_drv_reg && !sda_s &&
                    ((xmit && bit_reg < `TWM_ACK_BIT) ||
                     (!xmit && bit_reg == `TWM_ACK_BIT))) begin
                  sda_drv_next = 1'b0;
                  scl_drv_next = 1'b0;
                  code_next = `TWM_ST_ARB_LOST;
                  set_flag = 1'b1;
                  state_next = twm_pkg::TWM_HOLD;
                end else begin
                  scl_drv_next = 1'b1;
                  phase_next = 2'h3;
                end
              end
              default: begin
                if (bit_reg == `TWM_ACK_BIT) begin
                  sda_drv_next = 1'b0;
                  set_flag = 1'b1;
                  state_next = twm_pkg::TWM_HOLD;
                  if (addr_reg) begin
                    rx_mode_next = shift_reg[0];
                    if (shift_reg[0]) begin
                      code_next = ack_reg ? `TWM_ST_AR_ACK : `TWM_ST_AR_NACK;
                    end else begin
                      code_next = ack_reg ? `TWM_ST_AW_ACK : `TWM_ST_AW_NACK;
                    end
                  end else if (rx_mode_reg) begin
                    load_rx = 1'b1;
                    code_next = sda_drv_reg ? `TWM_ST_DR_ACK : `TWM_ST_DR_NACK;
                  end else begin
                    code_next = ack_reg ? `TWM_ST_DT_ACK : `TWM_ST_DT_NACK;
                  end
                end else begin
                  bit_next = bit_reg + 4'h1;
                  sda_drv_next = twm_sda_drive(xmit, bit_reg + 4'h1, shift_reg[7],
                                               ctrl_reg.ack_enable);
                  phase_next = 2'h0;
                end
              end
            endcase
          end
        end
        twm_pkg::TWM_HOLD: begin
          // clock held low while flag set, except after arbitration lost
          scl_drv_next = (code_reg != `TWM_ST_ARB_LOST);
          if (!ctrl_reg.event_flag) begin
            phase_next = 2'h0;
            bit_next = 4'h0;
            if (code_reg == `TWM_ST_ARB_LOST) begin
              scl_drv_next = 1'b0;
              state_next = twm_pkg::TWM_IDLE;
            end else if (ctrl_reg.stop_request) begin
              sda_drv_next = 1'b1;
              state_next = twm_pkg::TWM_STOP;
            end else if (ctrl_reg.start_request) begin
              sda_drv_next = 1'b0;
              state_next = twm_pkg::TWM_RSTART;
            end else if (code_reg == `TWM_ST_START || code_reg == `TWM_ST_RSTART) begin
              addr_next = 1'b1;
              shift_next = data_reg;
              sda_drv_next = twm_sda_drive(1'b1, 4'h0, data_reg[7], 1'b0);
              state_next = twm_pkg::TWM_SHIFT;
            end else if (code_reg == `TWM_ST_AR_ACK || code_reg == `TWM_ST_DR_ACK) begin
              addr_next = 1'b0;
              sda_drv_next = 1'b0;
              state_next = twm_pkg::TWM_SHIFT;
            end else if (code_reg == `TWM_ST_AW_ACK || code_reg == `TWM_ST_AW_NACK ||
                         code_reg == `TWM_ST_DT_ACK || code_reg == `TWM_ST_DT_NACK) begin
              // Transmitter mode: send data register
              addr_next = 1'b0;
              shift_next = data_reg;
              sda_drv_next = twm_sda_drive(1'b1, 4'h0, data_reg[7], 1'b0);
              state_next = twm_pkg::TWM_SHIFT;
            end
          end
        end
        twm_pkg::TWM_STOP: begin
          if (tick) begin
            case (phase_reg)
              2'h0: begin
                scl_drv_next = 1'b0;
                phase_next = 2'h1;
              end
              2'h1: begin
                if (scl_s) begin
                  sda_drv_next = 1'b0;
                  phase_next = 2'h2;
                end
              end
              2'h2: phase_next = 2'h3;
              default: begin
                stop_done = 1'b1;
                code_next = `TWM_ST_NONE;
                state_next = twm_pkg::TWM_IDLE;
              end
            endcase
          end
        end
        default: state_next = twm_pkg::TWM_IDLE;
      endcase
    end
  end

  // Engine flops
  always_ff @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= twm_pkg::TWM_IDLE;
      phase_reg <= 2'h0;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      code_reg <= `TWM_ST_NONE;
      rx_mode_reg <= 1'b0;
      addr_reg <= 1'b0;
      rep_reg <= 1'b0;
      ack_reg <= 1'b0;
      busy_reg <= 1'b0;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      scl_drv_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      code_reg <= code_next;
      rx_mode_reg <= rx_mode_next;
      addr_reg <= addr_next;
      rep_reg <= rep_next;
      ack_reg <= ack_next;
      busy_reg <= busy_next;
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
      scl_drv_reg <= scl_drv_next;
      sda_drv_reg <= sda_drv_next;
    end
  end

  // Open-drain pins: output level fixed low, enable pulls
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = scl_drv_reg;
  assign sda_oe_out = sda_drv_reg;
  assign reg_rdata_out = rdata_reg;

endmodule : twm_master_rx

/* File: twm_chk.sv */
// Port-level checker for the two-wire master receiver
`include "twm_consts.svh"
module twm_chk #(
  parameter int QUARTER_CYC = 4
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_out,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Enable bit as software last wrote it
  logic en_reg;
  logic en_next;
  // Register reads of control and status
  logic rd_ctrl;
  logic rd_stat;
  assign rd_ctrl = reg_rd_in && reg_addr_in == `TWM_CTRL_OFS;
  assign rd_stat = reg_rd_in && reg_addr_in == `TWM_STAT_OFS;
  // Next enable value from control writes
  always_comb begin
    en_next = en_reg;
    if (reg_wr_in && reg_addr_in == `TWM_CTRL_OFS) begin
      en_next = reg_wdata_in[`TWM_BIT_EN];
    end
  end
  // Enable tracking register
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      en_reg <= 1'b0;
    end else begin
      en_reg <= en_next;
    end
  end
  chk_rdata_idle: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == 8'h00) else $error("read data not zero");
  chk_pins_low: assert property (
    scl_out == 1'b0 && sda_out == 1'b0) else $error("pin drive level not low");
  chk_stat_low: assert property (
    $past(rd_stat) |-> reg_rdata_out[2:0] == 3'h0) else $error("status low bits set");
  chk_stat_code: assert property (
    $past(rd_stat) |-> reg_rdata_out inside {[8'h08:8'h58], 8'hF8})
    else $error("status code outside set");
  chk_ctrl_rsvd: assert property (
    $past(rd_ctrl) |-> reg_rdata_out[1] == 1'b0) else $error("reserved bit set");
  chk_en_off: assert property (
    !en_reg [*5] |-> !scl_oe_out && !sda_oe_out) else $error("bus driven while off");
  chk_scl_hold: assert property (
    $past(rd_ctrl) && reg_rdata_out[`TWM_BIT_FLAG] && reg_rdata_out[`TWM_BIT_EN]
    |-> scl_oe_out) else $error("clock free with flag");
  chk_reset_quiet: assert property (
    $rose(rst_b_in) |-> (!scl_oe_out && !sda_oe_out) [*3]) else $error("bus driven at reset");
  // Main outcomes seen by software
  cover property ($past(rd_stat) && reg_rdata_out == `TWM_ST_DR_ACK);
  cover property ($past(rd_stat) && reg_rdata_out == `TWM_ST_DR_NACK);
  cover property ($past(rd_stat) && reg_rdata_out == `TWM_ST_AR_NACK);
  cover property ($past(rd_stat) && reg_rdata_out == `TWM_ST_RSTART);
endmodule : twm_chk

/* File: twm_slave_model.sv */
// Behavioural slave transmitter on the two-wire bus
module twm_slave_model #(
  parameter logic [6:0] SLV_ADDR = 7'h50,
  parameter logic [7:0] DATA_BASE = 8'h96
) (
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic stretch_in,
  output logic scl_oe_out,
  output logic sda_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_scl = 1'b1;
  logic prev_sda = 1'b1;
  logic active = 1'b0;
  logic tx_mode = 1'b0;
  logic ack_seen = 1'b0;
  logic [7:0] shift = 8'h00;
  logic [7:0] addr_seen = 8'h00;
  logic [7:0] tx_byte = 8'h00;
  int bit_cnt = 0;
  int byte_idx = 0;
  initial begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
  end
  // Bus events: conditions, sampling on rise, shifting on fall
  always @(scl_in or sda_in) begin
    if (scl_in && prev_scl && !sda_in && prev_sda) begin
      active = 1'b1;
      tx_mode = 1'b0;
      // The master's own clock fall after START carries no bit
      bit_cnt = -1;
      sda_oe_out = 1'b0;
    end else if (scl_in && prev_scl && sda_in && !prev_sda) begin
      active = 1'b0;
      sda_oe_out = 1'b0;
    end else if (active && scl_in && !prev_scl) begin
      if (!tx_mode && bit_cnt < 8) shift = {shift[6:0], sda_in};
      if (tx_mode && bit_cnt == 8) ack_seen = !sda_in;
    end else if (active && !scl_in && prev_scl) begin
      bit_cnt++;
      if (bit_cnt == 8 && !tx_mode) begin
        addr_seen = shift;
        sda_oe_out = shift[7:1] == SLV_ADDR;
      end else if (bit_cnt == 9) begin
        bit_cnt = 0;
        if (tx_mode) byte_idx++;
        else byte_idx = 0;
        active = tx_mode ? ack_seen : sda_oe_out && shift[0];
        tx_mode = active;
        tx_byte = DATA_BASE + 8'(byte_idx);
        sda_oe_out = active && !tx_byte[7];
      end else if (tx_mode) begin
        sda_oe_out = bit_cnt < 8 && !tx_byte[7 - bit_cnt];
      end
    end
    prev_scl = scl_in;
    prev_sda = sda_in;
  end
  // Optional slow answer: stretch each low phase
  always @(negedge scl_in) begin
    if (stretch_in) begin
      scl_oe_out = 1'b1;
      #100 scl_oe_out = 1'b0;
    end
  end
endmodule : twm_slave_model

/* File: tb_top.sv */
// Testbench top: register tasks, bus wiring and scenarios
`include "twm_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] BASE = 8'h96;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic scl_o;
  logic scl_oe;
  logic sda_o;
  logic sda_oe;
  logic slv_scl_oe;
  logic slv_sda_oe;
  logic stretch = 1'b0;
  logic ext_oe = 1'b0;
  // Open-drain lines with pull-up
  wire scl_w = ~(scl_oe | slv_scl_oe);
  wire sda_w = ~(sda_oe | slv_sda_oe | ext_oe);
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] d;
  always #4 sys_clk = ~sys_clk;
  twm_master_rx #(.QUARTER_CYC(4)) DUT (.sys_clk_in(sys_clk), .rst_b_in(rst_b),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out(scl_oe),
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe));
  twm_slave_model #(.SLV_ADDR(7'h50), .DATA_BASE(BASE)) u_slave (.scl_in(scl_w),
    .sda_in(sda_w), .stretch_in(stretch), .scl_oe_out(slv_scl_oe), .sda_oe_out(slv_sda_oe));
  task automatic report_and_stop();
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : reg_rd
  // Poll for the event flag, then compare the status code
  task automatic wait_flag(input logic [7:0] code);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 400 && !c[7]; i++) reg_rd(`TWM_CTRL_OFS, c);
    check(c & 8'h80, 8'h80);
    reg_rd(`TWM_STAT_OFS, c);
    check(c, code);
  endtask : wait_flag
  task automatic go(input logic [7:0] ctrl, input logic [7:0] code);
    reg_wr(`TWM_CTRL_OFS, ctrl);
    wait_flag(code);
  endtask : go
  // Request STOP and wait for the stop bit to clear
  task automatic stop_bus();
    logic [7:0] c;
    c = 8'hFF;
    reg_wr(`TWM_CTRL_OFS, 8'h94);
    for (int i = 0; i < 400 && c[4] !== 1'b0; i++) reg_rd(`TWM_CTRL_OFS, c);
    check(c & 8'h90, 8'h00);
    reg_rd(`TWM_STAT_OFS, c);
    check(c, `TWM_ST_NONE);
  endtask : stop_bus
  task automatic t_regs();
    reg_rd(`TWM_CTRL_OFS, d);
    check(d, `TWM_CTRL_RST);
    reg_wr(`TWM_STAT_OFS, 8'h40);
    reg_rd(`TWM_STAT_OFS, d);
    check(d, `TWM_ST_NONE);
    reg_rd(8'h0C, d);
    check(d, 8'h00);
    // Start without enable must stay idle
    reg_wr(`TWM_CTRL_OFS, 8'hA0);
    repeat (60) @(negedge sys_clk);
    check({6'h00, scl_oe, sda_oe}, 8'h00);
    reg_rd(`TWM_STAT_OFS, d);
    check(d, `TWM_ST_NONE);
    reg_wr(`TWM_CTRL_OFS, 8'h00);
    reg_wr(`TWM_DATA_OFS, 8'h33);
    reg_rd(`TWM_CTRL_OFS, d);
    check(d & 8'h08, 8'h08);
    reg_rd(`TWM_DATA_OFS, d);
    check(d, `TWM_DATA_RST);
  endtask : t_regs
  task automatic t_receive();
    go(8'hA4, `TWM_ST_START);
    reg_wr(`TWM_DATA_OFS, 8'hA1);
    reg_rd(`TWM_CTRL_OFS, d);
    check(d & 8'h08, 8'h00);
    go(8'h84, `TWM_ST_AR_ACK);
    check(u_slave.addr_seen, 8'hA1);
    go(8'hC4, `TWM_ST_DR_ACK);
    reg_rd(`TWM_DATA_OFS, d);
    check(d, BASE);
    check({7'h00, u_slave.ack_seen}, 8'h01);
    go(8'h84, `TWM_ST_DR_NACK);
    reg_rd(`TWM_DATA_OFS, d);
    check(d, BASE + 8'h01);
    check({7'h00, u_slave.ack_seen}, 8'h00);
    go(8'hA4, `TWM_ST_RSTART);
    reg_wr(`TWM_DATA_OFS, 8'hA0);
    go(8'h84, `TWM_ST_AW_ACK);
    // Nobody listens to data after a write address: byte is refused
    reg_wr(`TWM_DATA_OFS, 8'h5A);
    go(8'h84, `TWM_ST_DT_NACK);
    stop_bus();
  endtask : t_receive
  task automatic t_restart();
    stretch <= 1'b1;
    go(8'hA4, `TWM_ST_START);
    reg_wr(`TWM_DATA_OFS, 8'hB3);
    go(8'h84, `TWM_ST_AR_NACK);
    go(8'hB4, `TWM_ST_START);
    reg_wr(`TWM_DATA_OFS, 8'hA1);
    go(8'h84, `TWM_ST_AR_ACK);
    go(8'h84, `TWM_ST_DR_NACK);
    check({7'h00, u_slave.ack_seen}, 8'h00);
    stop_bus();
    stretch <= 1'b0;
  endtask : t_restart
  task automatic t_busy();
    ext_oe <= 1'b1;
    repeat (20) @(posedge sys_clk);
    reg_wr(`TWM_CTRL_OFS, 8'hA4);
    repeat (80) @(negedge sys_clk);
    check({6'h00, scl_oe, sda_oe}, 8'h00);
    reg_rd(`TWM_STAT_OFS, d);
    check(d, `TWM_ST_NONE);
    ext_oe <= 1'b0;
    wait_flag(`TWM_ST_START);
    stop_bus();
  endtask : t_busy
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge sys_clk);
    t_regs();
    t_receive();
    t_restart();
    t_busy();
    report_and_stop();
  end
endmodule : tb_top
bind twm_master_rx twm_chk #(.QUARTER_CYC(QUARTER_CYC)) u_chk (.sys_clk_in(sys_clk_in),
  .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out));
